// >>> rtl/axr_ctrl.sv
// Purpose: Configuration lock and on/off control of the auxiliary regulator
// Assumes: All inputs synchronous to clk_i; resetn_i is power-on reset
// Notes: soft_reset_i clears everything except the configuration lock and the power-path registers
//
// Notes on behaviour
// - Stand-alone enable in Normal mode selects stand-alone configuration.
// - Load-share enable bit selects load-sharing configuration.
// - First selected configuration locks; later switch attempts ignored.
// - Lock survives soft reset, cleared only by power loss.
// - Stand-alone: select cleared gives 5.0V, set gives 3.3V.
// - Voltage select ignored in load-sharing configuration.
// - Off in Init/Fail-Safe; Normal configurable; per-config Stop/Sleep/Restart.
// - Load-sharing follows main regulator on/off in Normal and Restart; selectable in any mode.
// - Supply undervoltage turns regulator off; recovery re-enables it.
// - Undervoltage override keeps regulator on below threshold.
// - Load-sharing stays on in Stop only with keep-in-stop set.
// - Status flags reported for the supply status register.
// - Stop mode: base current above rising threshold enables high power.
// - Stop mode: below falling threshold disables high power path.
// - Normal mode runs only the high-power path.
// - Change attempt after load sharing locked sets SPI failure flag.
// - Stand-alone shunt threshold sets only overcurrent flag; clearable.
`timescale 1ns/10ps
`include "axr_map.svh"

module axr_ctrl
    import axr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic soft_reset_i,
    input axr_mode_e mode_i,
    input wire logic standalone_enable_i,
    input wire logic load_share_enable_i,
    input wire logic aux_voltage_select_i,
    input wire logic supply_uv_override_i,
    input wire logic share_keep_in_stop_i,
    input wire logic main_regulator_on_i,
    input wire logic supply_uv_i,
    input wire logic shunt_threshold_i,
    input wire logic oc_clear_i,
    input wire logic base_above_rise_i,
    input wire logic base_below_fall_i,
    output logic aux_regulator_on_o,
    output logic aux_vsel_3v3_o,
    output logic hp_enable_o,
    output logic lp_enable_o,
    output logic cfg_standalone_o,
    output logic cfg_share_o,
    output logic aux_overcurrent_flag_o,
    output logic aux_uv_flag_o,
    output logic spi_fail_set_o
);

    // ********************************************************
    // Decoding helpers
    // ********************************************************
    function automatic logic is_standalone(input axr_cfg_e cfg);
        return (cfg == AXR_CFG_STANDALONE);
    endfunction

    function automatic logic is_share(input axr_cfg_e cfg);
        return (cfg == AXR_CFG_SHARE);
    endfunction

    // Stand-alone selection only honoured in Normal mode
    function automatic logic standalone_request(input logic sa, input logic ls, input axr_mode_e mode);
        return sa && !ls && (mode == AXR_MODE_NORMAL);
    endfunction

    // Both bits at once is no valid request
    function automatic logic share_request(input logic sa, input logic ls);
        return ls && !sa;
    endfunction

    // ********************************************************
    // Configuration lock
    // ********************************************************
    axr_cfg_e cfg_q;
    axr_cfg_e cfg_d;
    logic fail_q;
    logic fail_d;

    always_comb
    begin
        cfg_d = cfg_q;
        fail_d = 1'b0;
        unique case (cfg_q)
            AXR_CFG_NONE:
            begin
                if (share_request(standalone_enable_i, load_share_enable_i))
                begin
                    cfg_d = AXR_CFG_SHARE;
                end
                else if (standalone_request(standalone_enable_i, load_share_enable_i, mode_i))
                begin
                    cfg_d = AXR_CFG_STANDALONE;
                end
            end
            AXR_CFG_STANDALONE:
            begin
                cfg_d = AXR_CFG_STANDALONE;
            end
            AXR_CFG_SHARE:
            begin
                fail_d = standalone_enable_i;
            end
            default:
            begin
                cfg_d = AXR_CFG_NONE;
            end
        endcase
    end

    // Soft reset never reaches the lock
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_q <= AXR_CFG_NONE;
            fail_q <= `AXR_RST_FLAG;
        end
        else if (en_i)
        begin
            cfg_q <= cfg_d;
            if (soft_reset_i)
            begin
                fail_q <= `AXR_RST_FLAG;
            end
            else
            begin
                fail_q <= fail_d;
            end
        end
    end

    // ********************************************************
    // Regulator on/off by chip mode
    // ********************************************************
    logic on_q;
    logic on_d;
    logic vsel_q;
    logic vsel_d;
    logic uv_block;

    assign uv_block = supply_uv_i && !supply_uv_override_i;

    always_comb
    begin
        on_d = on_q;
        vsel_d = vsel_q;
        if (is_standalone(cfg_q))
        begin
            unique case (mode_i)
                AXR_MODE_NORMAL:
                begin
                    on_d = standalone_enable_i;
                    vsel_d = aux_voltage_select_i ? `AXR_VSEL_3V3 : `AXR_VSEL_5V0;
                end
                AXR_MODE_INIT, AXR_MODE_FAILSAFE:
                begin
                    on_d = 1'b0;
                end
                AXR_MODE_STOP, AXR_MODE_SLEEP, AXR_MODE_RESTART:
                begin
                    on_d = on_q;
                end
                default:
                begin
                    on_d = 1'b0;
                end
            endcase
        end
        else if (is_share(cfg_q))
        begin
            vsel_d = `AXR_VSEL_5V0;
            unique case (mode_i)
                AXR_MODE_NORMAL, AXR_MODE_RESTART:
                begin
                    on_d = main_regulator_on_i;
                end
                AXR_MODE_STOP:
                begin
                    on_d = share_keep_in_stop_i && main_regulator_on_i;
                end
                AXR_MODE_INIT, AXR_MODE_SLEEP, AXR_MODE_FAILSAFE:
                begin
                    on_d = 1'b0;
                end
                default:
                begin
                    on_d = 1'b0;
                end
            endcase
        end
        else
        begin
            on_d = 1'b0;
        end
    end

    // Soft reset drops the regulator, the lock stays
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            on_q <= `AXR_RST_ON;
            vsel_q <= `AXR_VSEL_5V0;
        end
        else if (en_i)
        begin
            if (soft_reset_i)
            begin
                on_q <= `AXR_RST_ON;
                vsel_q <= `AXR_VSEL_5V0;
            end
            else
            begin
                on_q <= on_d;
                vsel_q <= vsel_d;
            end
        end
    end

    // ********************************************************
    // Status flags
    // ********************************************************
    logic oc_q;
    logic oc_d;
    logic uvf_q;
    logic uvf_d;

    always_comb
    begin
        oc_d = oc_q;
        if (oc_clear_i && !shunt_threshold_i)
        begin
            oc_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (is_standalone(cfg_q) && shunt_threshold_i)
        begin
            oc_d = 1'b1;
        end
        uvf_d = is_standalone(cfg_q) && uv_block && on_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            oc_q <= `AXR_RST_FLAG;
            uvf_q <= `AXR_RST_FLAG;
        end
        else if (en_i)
        begin
            if (soft_reset_i)
            begin
                oc_q <= `AXR_RST_FLAG;
                uvf_q <= `AXR_RST_FLAG;
            end
            else
            begin
                oc_q <= oc_d;
                uvf_q <= uvf_d;
            end
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    logic reg_on;

    assign reg_on = on_q && !uv_block;

    always_comb
    begin
        aux_regulator_on_o = reg_on;
        aux_vsel_3v3_o = vsel_q;
        cfg_standalone_o = is_standalone(cfg_q);
        cfg_share_o = is_share(cfg_q);
        aux_overcurrent_flag_o = oc_q;
        aux_uv_flag_o = uvf_q;
        spi_fail_set_o = fail_q;
    end

    axr_power_path u_power_path
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .en_i(en_i),
        .reg_on_i(reg_on),
        .mode_i(mode_i),
        .base_above_rise_i(base_above_rise_i),
        .base_below_fall_i(base_below_fall_i),
        .hp_enable_o(hp_enable_o),
        .lp_enable_o(lp_enable_o)
    );

endmodule // axr_ctrl

// >>> rtl/axr_map.svh
// Purpose: Named constants for the auxiliary regulator control block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef AXR_MAP_SVH
`define AXR_MAP_SVH

`define AXR_RST_LOCKED 1'b0
`define AXR_RST_FLAG 1'b0
`define AXR_RST_ON 1'b0
`define AXR_VSEL_5V0 1'b0
`define AXR_VSEL_3V3 1'b1

`endif

// >>> rtl/axr_pkg.sv
// Purpose: Types for the auxiliary regulator control block
// Assumes: Included header supplies the constants
// Notes: Types only
package axr_pkg;

    // Chip operating modes as seen by this block
    typedef enum logic [2:0]
    {
        AXR_MODE_INIT,
        AXR_MODE_NORMAL,
        AXR_MODE_STOP,
        AXR_MODE_SLEEP,
        AXR_MODE_RESTART,
        AXR_MODE_FAILSAFE
    } axr_mode_e;

    // Locked configuration
    typedef enum logic [1:0]
    {
        AXR_CFG_NONE,
        AXR_CFG_STANDALONE,
        AXR_CFG_SHARE
    } axr_cfg_e;

endpackage

// >>> rtl/axr_power_path.sv
// Purpose: Low-power / high-power regulator path selection
// Assumes: Base-current comparators are synchronous to clk_i
// Notes: Hysteresis between rising and falling peak thresholds
`timescale 1ns/10ps
`include "axr_map.svh"

module axr_power_path
    import axr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic reg_on_i,
    input axr_mode_e mode_i,
    input wire logic base_above_rise_i,
    input wire logic base_below_fall_i,
    output logic hp_enable_o,
    output logic lp_enable_o
);

    logic hp_q;
    logic hp_d;
    logic lp_q;
    logic lp_d;

    always_comb
    begin
        hp_d = hp_q;
        lp_d = lp_q;
        if (!reg_on_i)
        begin
            hp_d = 1'b0;
            lp_d = 1'b0;
        end
        else if (mode_i == AXR_MODE_STOP)
        begin
            lp_d = 1'b1;
            if (base_above_rise_i)
            begin
                hp_d = 1'b1;
            end
            else if (base_below_fall_i)
            begin
                hp_d = 1'b0;
            end
        end
        else
        begin
            hp_d = 1'b1;
            lp_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hp_q <= `AXR_RST_ON;
            lp_q <= `AXR_RST_ON;
        end
        else if (en_i)
        begin
            hp_q <= hp_d;
            lp_q <= lp_d;
        end
    end

    assign hp_enable_o = hp_q;
    assign lp_enable_o = lp_q;

endmodule // axr_power_path

// >>> sim/axr_ctrl_checker.sv
// Purpose: Port assertions for axr_ctrl
// Assumes: Single clock domain
// Notes: Bound below the module
`timescale 1ns/10ps
module axr_ctrl_checker
    import axr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input axr_mode_e mode_i,
    input wire logic standalone_enable_i,
    input wire logic supply_uv_i,
    input wire logic supply_uv_override_i,
    input wire logic shunt_threshold_i,
    input wire logic base_above_rise_i,
    input wire logic aux_regulator_on_o,
    input wire logic aux_vsel_3v3_o,
    input wire logic lp_enable_o,
    input wire logic hp_enable_o,
    input wire logic cfg_standalone_o,
    input wire logic cfg_share_o,
    input wire logic aux_overcurrent_flag_o,
    input wire logic spi_fail_set_o
);
    // ****
    // Assertions
    // ****
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    uv_off_a: assert property (supply_uv_i && !supply_uv_override_i |-> !aux_regulator_on_o)
        else $error("On during undervoltage");
    init_off_a: assert property (en_i && mode_i inside {AXR_MODE_INIT, AXR_MODE_FAILSAFE} |=> !aux_regulator_on_o)
        else $error("On in init or fail-safe");
    one_cfg_a: assert property (!(cfg_standalone_o && cfg_share_o))
        else $error("Both configurations set");
    lock_hold_a: assert property (cfg_standalone_o || cfg_share_o |=> $stable({cfg_standalone_o, cfg_share_o}))
        else $error("Configuration changed");
    share_5v_a: assert property (cfg_share_o ##1 cfg_share_o |-> !aux_vsel_3v3_o)
        else $error("Share not at 5V");
    fail_flag_a: assert property (en_i && cfg_share_o && standalone_enable_i |=> spi_fail_set_o)
        else $error("No failure flag");
    oc_set_a: assert property (en_i && cfg_standalone_o && shunt_threshold_i |=> aux_overcurrent_flag_o)
        else $error("Overcurrent flag not set");
    normal_hp_a: assert property (en_i && mode_i == AXR_MODE_NORMAL |=> !lp_enable_o)
        else $error("Low power path in normal");
    hp_rise_a: assert property ($rose(hp_enable_o) && $past(mode_i) == AXR_MODE_STOP |-> $past(base_above_rise_i))
        else $error("High power without peak");
    cover property (cfg_share_o && spi_fail_set_o);
    cover property ($rose(hp_enable_o));
    cover property (supply_uv_i && aux_regulator_on_o);
endmodule // axr_ctrl_checker

bind axr_ctrl axr_ctrl_checker u_chk (.clk_i, .resetn_i, .en_i, .mode_i, .standalone_enable_i, .supply_uv_i,
    .supply_uv_override_i, .shunt_threshold_i, .base_above_rise_i, .aux_regulator_on_o, .aux_vsel_3v3_o,
    .lp_enable_o, .hp_enable_o, .cfg_standalone_o, .cfg_share_o, .aux_overcurrent_flag_o, .spi_fail_set_o);

// >>> sim/axr_ctrl_test.sv
// Purpose: Self-checking bench for axr_ctrl
// Assumes: Inputs change at the falling edge
// Notes: Two power-ups, one per configuration
`timescale 1ns/10ps
`include "axr_map.svh"
module axr_ctrl_test
    import axr_pkg::*;
;
    logic clk_i = 1'b0, resetn_i = 1'b0, en_i = 1'b1, soft_reset_i = 1'b0;
    axr_mode_e mode_i = AXR_MODE_INIT;
    logic standalone_enable_i = 1'b0, load_share_enable_i = 1'b0, aux_voltage_select_i = 1'b0;
    logic supply_uv_override_i = 1'b0, share_keep_in_stop_i = 1'b0, main_regulator_on_i = 1'b0;
    logic supply_uv_i = 1'b0, shunt_threshold_i = 1'b0, oc_clear_i = 1'b0;
    logic base_above_rise_i, base_below_fall_i, aux_regulator_on_o, aux_vsel_3v3_o, hp_enable_o, lp_enable_o;
    logic cfg_standalone_o, cfg_share_o, aux_overcurrent_flag_o, aux_uv_flag_o, spi_fail_set_o;
    logic [7:0] base_level = 8'h00;
    int failures = 0;
    int n_tests = 0;

    always #4 clk_i = ~clk_i;

    axr_ctrl u_dut (.*);
    axr_pnp_model u_pnp (.base_i(base_level), .above_o(base_above_rise_i), .below_o(base_below_fall_i));

    // ****
    // Tasks
    // ****
    task automatic chk(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic power_up;
        resetn_i = 1'b0;
        step(5);
        resetn_i = 1'b1;
        step(1);
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****
    // Tests
    // ****
    initial
    begin
        power_up();
        mode_i = AXR_MODE_NORMAL;
        standalone_enable_i = 1'b1;
        aux_voltage_select_i = 1'b1;
        step(2);
        chk(cfg_standalone_o, 1'b1);
        chk(aux_regulator_on_o, 1'b1);
        chk(aux_vsel_3v3_o, `AXR_VSEL_3V3);
        load_share_enable_i = 1'b1;
        aux_voltage_select_i = 1'b0;
        step(2);
        chk(cfg_share_o, 1'b0);
        chk(spi_fail_set_o, 1'b0);
        chk(aux_vsel_3v3_o, `AXR_VSEL_5V0);
        supply_uv_i = 1'b1;
        #1 chk(aux_regulator_on_o, 1'b0);
        step(2);
        chk(aux_uv_flag_o, 1'b1);
        supply_uv_override_i = 1'b1;
        #1 chk(aux_regulator_on_o, 1'b1);
        step(1);
        supply_uv_i = 1'b0;
        supply_uv_override_i = 1'b0;
        #1 chk(aux_regulator_on_o, 1'b1);
        shunt_threshold_i = 1'b1;
        oc_clear_i = 1'b1;
        step(2);
        chk(aux_overcurrent_flag_o, 1'b1);
        shunt_threshold_i = 1'b0;
        step(2);
        chk(aux_overcurrent_flag_o, 1'b0);
        oc_clear_i = 1'b0;
        mode_i = AXR_MODE_STOP;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        chk(lp_enable_o, 1'b1);
        base_level = 8'h20;
        step(2);
        chk(hp_enable_o, 1'b1);
        base_level = 8'h10;
        step(2);
        chk(hp_enable_o, 1'b1);
        base_level = 8'h00;
        step(2);
        chk(hp_enable_o, 1'b0);
        mode_i = AXR_MODE_NORMAL;
        step(2);
        chk(hp_enable_o, 1'b1);
        chk(lp_enable_o, 1'b0);
        mode_i = AXR_MODE_SLEEP;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        mode_i = AXR_MODE_RESTART;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        mode_i = AXR_MODE_INIT;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        soft_reset_i = 1'b1;
        step(1);
        soft_reset_i = 1'b0;
        chk(cfg_standalone_o, 1'b1);
        $display("Test stand-alone done");
        standalone_enable_i = 1'b0;
        load_share_enable_i = 1'b0;
        power_up();
        mode_i = AXR_MODE_NORMAL;
        load_share_enable_i = 1'b1;
        main_regulator_on_i = 1'b1;
        aux_voltage_select_i = 1'b1;
        step(2);
        chk(cfg_share_o, 1'b1);
        chk(aux_regulator_on_o, 1'b1);
        chk(aux_vsel_3v3_o, `AXR_VSEL_5V0);
        main_regulator_on_i = 1'b0;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        main_regulator_on_i = 1'b1;
        standalone_enable_i = 1'b1;
        step(1);
        chk(spi_fail_set_o, 1'b1);
        standalone_enable_i = 1'b0;
        step(1);
        chk(cfg_standalone_o, 1'b0);
        en_i = 1'b0;
        main_regulator_on_i = 1'b0;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        en_i = 1'b1;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        main_regulator_on_i = 1'b1;
        shunt_threshold_i = 1'b1;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        chk(aux_overcurrent_flag_o, 1'b0);
        shunt_threshold_i = 1'b0;
        supply_uv_i = 1'b1;
        #1 chk(aux_regulator_on_o, 1'b0);
        step(2);
        chk(aux_uv_flag_o, 1'b0);
        supply_uv_i = 1'b0;
        #1 chk(aux_regulator_on_o, 1'b1);
        step(1);
        mode_i = AXR_MODE_STOP;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        share_keep_in_stop_i = 1'b1;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        mode_i = AXR_MODE_SLEEP;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        mode_i = AXR_MODE_RESTART;
        step(2);
        chk(aux_regulator_on_o, 1'b1);
        mode_i = AXR_MODE_FAILSAFE;
        step(2);
        chk(aux_regulator_on_o, 1'b0);
        $display("Test load-sharing done");
        give_verdict();
    end

    initial
    begin
        #20000;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // axr_ctrl_test

// >>> sim/axr_pnp_model.sv
// Purpose: Base-current comparators of the external pass transistor
// Assumes: Base current given as a level in arbitrary units
// Notes: Thresholds are plain defaults
`timescale 1ns/10ps
module axr_pnp_model #(
    parameter logic [7:0] RISE = 8'h14,
    parameter logic [7:0] FALL = 8'h0a
)
(
    input wire logic [7:0] base_i,
    output logic above_o,
    output logic below_o
);
    assign above_o = base_i > RISE;
    assign below_o = base_i < FALL;
endmodule // axr_pnp_model
